// >>> rtl/nbr_regs.vh
/*
 Constants of the network boot load requester: message codes, protocol classes,
 image selectors and timing figures. Assumes the 50 MHz system clock.
*/
`ifndef NBR_REGS_VH
`define NBR_REGS_VH
// protocol classes of a parsed frame
`define NBR_PROTO_NONE     3'h0
`define NBR_PROTO_DUMPLOAD 3'h1
`define NBR_PROTO_CONSOLE  3'h2
`define NBR_PROTO_LOOP     3'h3
`define NBR_PROTO_LLC      3'h4
// message codes
`define NBR_CODE_XFER      8'h00
`define NBR_CODE_MEMLOAD   8'h02
`define NBR_CODE_VOLUNTEER 8'h03
`define NBR_CODE_REQ_ID    8'h05
`define NBR_CODE_BOOT      8'h06
`define NBR_CODE_SYS_ID    8'h07
`define NBR_CODE_REQ_PROG  8'h08
`define NBR_CODE_REQ_CNT   8'h09
`define NBR_CODE_REQ_LOAD  8'h0A
`define NBR_CODE_COUNTERS  8'h0B
`define NBR_CODE_PARM_XFER 8'h14
`define NBR_LOOP_FORWARD   8'h02
`define NBR_LOOP_REPLY     8'h01
`define NBR_XID_FORMAT     8'h81
`define NBR_XID_CLASS      8'h01
`define NBR_XID_RXWIN      8'h00
// multicast destinations
`define NBR_MCAST_DUMPLOAD 48'hAB0000010000
`define NBR_MCAST_CONSOLE  48'hAB0000020000
// image selectors handed to the framer
`define NBR_IMG_SYSTEM     2'h0
`define NBR_IMG_DIAG       2'h1
`define NBR_IMG_NAMED      2'h2
// file specification limits
`define NBR_FILE_MAX_V4    6'h27
`define NBR_FILE_MAX_V3    6'h0F
// timing: one second is split into sub-ticks
`define NBR_CLK_HZ         50000000
`define NBR_SUBTICKS_PER_S 512
`define NBR_BURST_LEN      4'h8
`define NBR_BURST_GAP_S    4
`define NBR_BACKOFF_MIN_S  9'h004
`define NBR_BACKOFF_MAX_MIN 5
`define NBR_BACKOFF_MAX_S  (`NBR_BACKOFF_MAX_MIN * 60)
`define NBR_SYSID_MIN_MIN  8
`define NBR_SYSID_MAX_MIN  12
`define NBR_JITTER_BASE    10'h180
`endif

// >>> rtl/nbr_requester.v
/*
 Boot load requester with maintenance listener and its load-data FIFO.
 Assumes a parser giving one decoded message per rx_msg_valid pulse, after the
 data bytes, and a framer taking the tx_* fields while tx_valid and tx_ready are high.
*/
`timescale 1ns/1ps
`include "nbr_regs.vh"

module nbr_fifo #(
    parameter WIDTH = 8,
    parameter DEPTH = 16,
    parameter AW    = 4
) (
    // clock and reset
    input  wire             clock,
    input  wire             rst,
    // fill side
    input  wire [WIDTH-1:0] in_data,
    input  wire             in_valid,
    output reg              in_ready,
    // drain side
    output wire [WIDTH-1:0] out_data,
    output reg              out_valid,
    input  wire             out_ready
);
    reg [WIDTH-1:0] mem [0:DEPTH-1];
    reg [AW-1:0]    wr_ptr;
    reg [AW-1:0]    rd_ptr;
    reg [AW:0]      count;
    wire            push = in_valid & in_ready;
    wire            pop  = out_valid & out_ready;
    wire [AW:0]     next_count = count + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};

    assign out_data = mem[rd_ptr];

    always @(posedge clock) begin
        if (push) begin
            mem[wr_ptr] <= in_data;
        end
    end

    always @(posedge clock or posedge rst) begin
        if (rst) begin
            wr_ptr    <= {AW{1'b0}};
            rd_ptr    <= {AW{1'b0}};
            count     <= {(AW+1){1'b0}};
            in_ready  <= 1'b0;
            out_valid <= 1'b0;
        end else begin
            if (push) begin
                wr_ptr <= wr_ptr + 1'b1;
            end
            if (pop) begin
                rd_ptr <= rd_ptr + 1'b1;
            end
            count     <= next_count;
            // flags follow next_count, so no lag
            in_ready  <= (next_count != DEPTH);
            out_valid <= (next_count != {(AW+1){1'b0}});
        end
    end
endmodule // nbr_fifo

module nbr_requester #(
    parameter SUBTICK_CYCLES = `NBR_CLK_HZ / `NBR_SUBTICKS_PER_S
) (
    // clock and reset
    input  wire         clock,
    input  wire         rst,
    // boot control
    input  wire         boot_start,
    input  wire         operator_halt,
    input  wire         fatal_error,
    input  wire         diag_image_flag,
    input  wire         solicit_file_flag,
    input  wire [5:0]   file_spec_len,
    // decoded receive message
    input  wire         rx_msg_valid,
    input  wire         rx_to_us,
    input  wire [2:0]   rx_proto,
    input  wire         rx_ieee,
    input  wire [7:0]   rx_code,
    input  wire [47:0]  rx_src,
    input  wire [7:0]   rx_load_num,
    input  wire [15:0]  rx_receipt,
    input  wire         rx_good,
    // load image bytes from the parser
    input  wire [7:0]   rx_data,
    input  wire         rx_data_valid,
    output wire         rx_data_ready,
    // image bytes toward memory
    output wire [7:0]   mem_data,
    output wire         mem_valid,
    input  wire         mem_ready,
    // transmit request to the framer
    output reg          tx_valid,
    output reg  [7:0]   tx_code,
    output reg  [2:0]   tx_proto,
    output reg          tx_ieee,
    output reg  [47:0]  tx_dst,
    output reg  [7:0]   tx_load_num,
    output reg  [15:0]  tx_receipt,
    output reg          tx_nopad,
    output reg  [5:0]   tx_swid_len,
    output reg  [1:0]   tx_image_sel,
    input  wire         tx_ready,
    // status
    output reg          booting,
    output reg          boot_done,
    output reg          boot_failed
);
    localparam S_IDLE  = 3'h0;
    localparam S_SOL   = 3'h1;
    localparam S_BACK  = 3'h2;
    localparam S_ACK   = 3'h3;
    localparam S_LREQ  = 3'h4;
    localparam S_LWAIT = 3'h5;
    localparam S_DRAIN = 3'h6;
    localparam S_FIN   = 3'h7;

    localparam [18:0] GAP_SUB   = `NBR_BURST_GAP_S * `NBR_SUBTICKS_PER_S;
    localparam [8:0]  BK_MAX    = `NBR_BACKOFF_MAX_S;
    localparam [9:0]  SID_MIN_S = `NBR_SYSID_MIN_MIN * 60;
    localparam [17:0] SID_SPAN  = (`NBR_SYSID_MAX_MIN - `NBR_SYSID_MIN_MIN) * 60;

    reg [2:0]   st;
    reg [31:0]  div_cnt;
    reg         sub_pulse;
    reg [8:0]   sub_cnt;
    reg         sec_pulse;
    reg [15:0]  lfsr;
    reg [18:0]  wt;
    reg [3:0]   bcnt;
    reg [8:0]   backoff;
    reg [47:0]  srv_addr;
    reg         ver_known;
    reg         srv_ieee;
    reg [7:0]   load_num;
    reg         term;
    reg [9:0]   sid_left;
    reg         sid_pend;
    reg         sid_second;
    reg         rp_valid;
    reg [7:0]   rp_code;
    reg [2:0]   rp_proto;
    reg         rp_ieee;
    reg         rp_nopad;
    reg [47:0]  rp_dst;
    reg [15:0]  rp_receipt;
    reg         mem_seen;

    wire        accept = rx_msg_valid & rx_to_us & booting &
                         (rx_proto != `NBR_PROTO_NONE) & (rx_proto <= `NBR_PROTO_LLC);
    wire        dl_msg = accept & (rx_proto == `NBR_PROTO_DUMPLOAD);
    wire        boot_wants = ((st == S_SOL) & (wt == 19'h00000)) | (st == S_ACK) |
                             (st == S_LREQ) | (st == S_FIN);
    wire        tx_free = ~tx_valid | tx_ready;
    wire [18:0] jitter_wait = backoff * (`NBR_JITTER_BASE + {2'b00, lfsr[7:0]});
    wire [17:0] sid_rnd = lfsr[15:8] * SID_SPAN;
    wire [9:0]  sid_reload = SID_MIN_S + {2'b00, sid_rnd[15:8]};
    wire [9:0]  backoff_x2 = {backoff, 1'b0};
    wire [5:0]  len_v4 = (file_spec_len > `NBR_FILE_MAX_V4) ? `NBR_FILE_MAX_V4 : file_spec_len;
    wire        prog_ieee = (st == S_SOL) ? (bcnt < 4'h4) : srv_ieee;
    wire        fifo_empty = ~mem_valid;

    // buffer lets memory stalls back up
    nbr_fifo #(
        .WIDTH (8),
        .DEPTH (16),
        .AW    (4)
    ) u_fifo (
        .clock     (clock),
        .rst       (rst),
        .in_data   (rx_data),
        .in_valid  (rx_data_valid),
        .in_ready  (rx_data_ready),
        .out_data  (mem_data),
        .out_valid (mem_valid),
        .out_ready (mem_ready)
    );

    // free-running divider and pseudo-random source
    always @(posedge clock or posedge rst) begin
        if (rst) begin
            div_cnt   <= 32'h00000000;
            sub_pulse <= 1'b0;
            sub_cnt   <= 9'h000;
            sec_pulse <= 1'b0;
            lfsr      <= 16'hACE1;
        end else begin
            lfsr      <= {lfsr[14:0], lfsr[15] ^ lfsr[13] ^ lfsr[12] ^ lfsr[10]};
            sub_pulse <= 1'b0;
            sec_pulse <= 1'b0;
            if (div_cnt >= SUBTICK_CYCLES - 1) begin
                div_cnt   <= 32'h00000000;
                sub_pulse <= 1'b1;
                sub_cnt   <= sub_cnt + 1'b1;
                sec_pulse <= (sub_cnt == 9'h1FF);
            end else begin
                div_cnt <= div_cnt + 1'b1;
            end
        end
    end

    always @(posedge clock or posedge rst) begin
        if (rst) begin
            st           <= S_IDLE;
            wt           <= 19'h00000;
            bcnt         <= 4'h0;
            backoff      <= `NBR_BACKOFF_MIN_S;
            srv_addr     <= `NBR_MCAST_DUMPLOAD;
            ver_known    <= 1'b0;
            srv_ieee     <= 1'b0;
            load_num     <= 8'h00;
            term         <= 1'b0;
            mem_seen     <= 1'b0;
            sid_left     <= 10'h000;
            sid_pend     <= 1'b0;
            sid_second   <= 1'b0;
            rp_valid     <= 1'b0;
            rp_code      <= 8'h00;
            rp_proto     <= `NBR_PROTO_NONE;
            rp_ieee      <= 1'b0;
            rp_nopad     <= 1'b0;
            rp_dst       <= 48'h000000000000;
            rp_receipt   <= 16'h0000;
            tx_valid     <= 1'b0;
            tx_code      <= 8'h00;
            tx_proto     <= `NBR_PROTO_NONE;
            tx_ieee      <= 1'b0;
            tx_dst       <= 48'h000000000000;
            tx_load_num  <= 8'h00;
            tx_receipt   <= 16'h0000;
            tx_nopad     <= 1'b0;
            tx_swid_len  <= 6'h00;
            tx_image_sel <= `NBR_IMG_SYSTEM;
            booting      <= 1'b0;
            boot_done    <= 1'b0;
            boot_failed  <= 1'b0;
        end else begin
            if (sub_pulse && wt != 19'h00000) begin
                wt <= wt - 1'b1;
            end
            // identification timer runs only while listening
            if (booting && sec_pulse) begin
                if (sid_left == 10'h000) begin
                    sid_pend   <= 1'b1;
                    sid_second <= 1'b0;
                    sid_left   <= sid_reload;
                end else begin
                    sid_left <= sid_left - 1'b1;
                end
            end

            // transmit slot: replies first, then boot traffic, then identification
            if (tx_valid && tx_ready) begin
                tx_valid <= 1'b0;
            end
            if (tx_free) begin
                if (rp_valid) begin
                    tx_valid   <= 1'b1;
                    tx_code    <= rp_code;
                    tx_proto   <= rp_proto;
                    tx_ieee    <= rp_ieee;
                    tx_dst     <= rp_dst;
                    tx_receipt <= rp_receipt;
                    tx_nopad   <= rp_nopad;
                    rp_valid   <= 1'b0;
                end else if (boot_wants) begin
                    tx_valid    <= 1'b1;
                    tx_proto    <= `NBR_PROTO_DUMPLOAD;
                    tx_dst      <= srv_addr;
                    tx_receipt  <= 16'h0000;
                    tx_nopad    <= 1'b0;
                    tx_load_num <= load_num;
                    tx_ieee     <= prog_ieee;
                    if (st == S_SOL || st == S_ACK) begin
                        tx_code <= `NBR_CODE_REQ_PROG;
                    end else begin
                        tx_code <= `NBR_CODE_REQ_LOAD;
                    end
                    if (solicit_file_flag) begin
                        tx_image_sel <= `NBR_IMG_NAMED;
                        tx_swid_len <= (!prog_ieee && len_v4 > `NBR_FILE_MAX_V3) ?
                                       `NBR_FILE_MAX_V3 : len_v4;
                    end else begin
                        tx_image_sel <= diag_image_flag ? `NBR_IMG_DIAG : `NBR_IMG_SYSTEM;
                        tx_swid_len  <= 6'h00;
                    end
                    case (st)
                        S_SOL: begin
                            if (bcnt == `NBR_BURST_LEN - 1'b1) begin
                                bcnt <= 4'h0;
                                st   <= S_BACK;
                                wt   <= jitter_wait;
                            end else begin
                                bcnt <= bcnt + 1'b1;
                                wt   <= GAP_SUB;
                            end
                        end
                        S_ACK: begin
                            st <= S_LREQ;
                        end
                        S_LREQ: begin
                            st <= S_LWAIT;
                            wt <= GAP_SUB;
                        end
                        S_FIN: begin
                            st        <= S_IDLE;
                            booting   <= 1'b0;
                            boot_done <= 1'b1;
                        end
                        default: begin
                            st <= st;
                        end
                    endcase
                end else if (sid_pend) begin
                    tx_valid   <= 1'b1;
                    tx_code    <= `NBR_CODE_SYS_ID;
                    tx_proto   <= `NBR_PROTO_CONSOLE;
                    tx_dst     <= `NBR_MCAST_CONSOLE;
                    tx_receipt <= 16'h0000;
                    tx_nopad   <= 1'b0;
                    if (ver_known) begin
                        tx_ieee  <= srv_ieee;
                        sid_pend <= 1'b0;
                    end else begin
                        tx_ieee    <= ~sid_second;
                        sid_second <= ~sid_second;
                        sid_pend   <= ~sid_second;
                    end
                end
            end

            // listener: a new request wins over the slot clear above
            if (accept) begin
                rp_dst     <= rx_src;
                rp_ieee    <= rx_ieee;
                rp_proto   <= rx_proto;
                rp_receipt <= rx_receipt;
                rp_nopad   <= 1'b0;
                case (rx_proto)
                    `NBR_PROTO_CONSOLE: begin
                        if (rx_code == `NBR_CODE_REQ_ID) begin
                            rp_valid <= 1'b1;
                            rp_code  <= `NBR_CODE_SYS_ID;
                        end else if (rx_code == `NBR_CODE_REQ_CNT) begin
                            rp_valid <= 1'b1;
                            rp_code  <= `NBR_CODE_COUNTERS;
                        end else if (rx_code == `NBR_CODE_BOOT) begin
                            backoff <= `NBR_BACKOFF_MIN_S;
                        end
                    end
                    `NBR_PROTO_LOOP: begin
                        if (rx_code == `NBR_LOOP_FORWARD) begin
                            rp_valid <= 1'b1;
                            rp_code  <= `NBR_LOOP_REPLY;
                            rp_nopad <= ~rx_ieee;
                        end
                    end
                    `NBR_PROTO_LLC: begin
                        // framer adds format/class/window fields for xid
                        rp_valid <= 1'b1;
                        rp_code  <= rx_code;
                    end
                    default: begin
                        rp_code <= rp_code;
                    end
                endcase
            end

            // boot sequence
            case (st)
                S_IDLE: begin
                    if (boot_start) begin
                        st          <= S_SOL;
                        booting     <= 1'b1;
                        boot_done   <= 1'b0;
                        boot_failed <= 1'b0;
                        bcnt        <= 4'h0;
                        wt          <= 19'h00000;
                        backoff     <= `NBR_BACKOFF_MIN_S;
                        srv_addr    <= `NBR_MCAST_DUMPLOAD;
                        ver_known   <= 1'b0;
                        load_num    <= 8'h00;
                        sid_left    <= sid_reload;
                        sid_pend    <= 1'b0;
                    end
                end
                S_SOL, S_BACK: begin
                    if (dl_msg && rx_code == `NBR_CODE_VOLUNTEER) begin
                        st        <= S_ACK;
                        srv_addr  <= rx_src;
                        srv_ieee  <= rx_ieee;
                        ver_known <= 1'b1;
                    end else if (st == S_BACK && wt == 19'h00000) begin
                        st <= S_SOL;
                        backoff <= (backoff_x2 > {1'b0, BK_MAX}) ? BK_MAX : backoff_x2[8:0];
                    end
                end
                S_LWAIT: begin
                    if (dl_msg && rx_good && rx_load_num == load_num &&
                        (rx_code == `NBR_CODE_MEMLOAD || rx_code == `NBR_CODE_XFER ||
                         rx_code == `NBR_CODE_PARM_XFER)) begin
                        st       <= S_DRAIN;
                        term     <= (rx_code != `NBR_CODE_MEMLOAD);
                        mem_seen <= 1'b0;
                    end else if (wt == 19'h00000) begin
                        st <= S_LREQ;
                    end
                end
                S_DRAIN: begin
                    // fifo flag tested from the second drain cycle on
                    mem_seen <= 1'b1;
                    if (mem_seen && fifo_empty) begin
                        load_num <= load_num + 1'b1;
                        st       <= term ? S_FIN : S_LREQ;
                    end
                end
                default: begin
                    // advanced in the transmit slot
                end
            endcase

            // abort overrides the st, booting and sid_pend values set by the steps above
            if (booting && (operator_halt || fatal_error)) begin
                st          <= S_IDLE;
                booting     <= 1'b0;
                boot_failed <= fatal_error;
                sid_pend    <= 1'b0;
            end
        end
    end
endmodule // nbr_requester

// >>> tb/nbr_chk.sv
/* port checker for nbr_requester, bound to every instance.
   assumes tx requests hold until taken */
`timescale 1ns/1ps
`include "nbr_regs.vh"
module nbr_chk (
    // clock and reset
    input wire        clock,
    input wire        rst,
    // inputs
    input wire        operator_halt,
    input wire        fatal_error,
    input wire        diag_image_flag,
    input wire        solicit_file_flag,
    input wire        rx_msg_valid,
    input wire        rx_to_us,
    input wire [2:0]  rx_proto,
    input wire [7:0]  rx_code,
    input wire        tx_ready,
    // outputs
    input wire        tx_valid,
    input wire [7:0]  tx_code,
    input wire [47:0] tx_dst,
    input wire        tx_ieee,
    input wire [5:0]  tx_swid_len,
    input wire [1:0]  tx_image_sel,
    input wire        booting,
    input wire        boot_failed
);
    default clocking cb @(posedge clock); endclocking
    default disable iff (rst);
    property p_hold; tx_valid && !tx_ready |=> tx_valid && $stable({tx_code, tx_dst}); endproperty
    a_hold: assert property (p_hold) else $error("tx request moved before taken");
    property p_start; $rose(booting) |=> tx_valid && tx_ieee && tx_code == 8'h08
        && tx_dst == `NBR_MCAST_DUMPLOAD; endproperty
    a_start: assert property (p_start) else $error("no first program request");
    property p_halt; operator_halt |=> !booting; endproperty
    a_halt: assert property (p_halt) else $error("halt did not stop boot");
    property p_fatal; fatal_error && booting |=> boot_failed && !booting; endproperty
    a_fatal: assert property (p_fatal) else $error("fatal error not reported");
    property p_sel; tx_valid && tx_code == 8'h08 |-> tx_image_sel ==
        (solicit_file_flag ? `NBR_IMG_NAMED : {1'b0, diag_image_flag}); endproperty
    a_sel: assert property (p_sel) else $error("wrong image selector");
    property p_len; tx_valid |-> tx_swid_len <= 6'h27 && (tx_ieee || tx_swid_len <= 6'h0F);
    endproperty
    a_len: assert property (p_len) else $error("file name too long");
    property p_id; rx_msg_valid && rx_to_us && booting && rx_proto == 3'h2 && rx_code == 8'h05
        && !tx_valid |-> ##[1:2] tx_valid && tx_code == 8'h07; endproperty
    a_id: assert property (p_id) else $error("no identification reply");
    property p_cnt; rx_msg_valid && rx_to_us && booting && rx_proto == 3'h2 && rx_code == 8'h09
        && !tx_valid |-> ##[1:2] tx_valid && tx_code == 8'h0B; endproperty
    a_cnt: assert property (p_cnt) else $error("no counters reply");
endmodule // nbr_chk

bind nbr_requester nbr_chk u_chk (.clock(clock), .rst(rst), .operator_halt(operator_halt),
    .fatal_error(fatal_error), .diag_image_flag(diag_image_flag), .rx_code(rx_code),
    .solicit_file_flag(solicit_file_flag), .rx_msg_valid(rx_msg_valid), .rx_to_us(rx_to_us),
    .rx_proto(rx_proto), .tx_ready(tx_ready), .tx_valid(tx_valid), .tx_code(tx_code),
    .tx_dst(tx_dst), .tx_ieee(tx_ieee), .tx_swid_len(tx_swid_len),
    .tx_image_sel(tx_image_sel), .booting(booting), .boot_failed(boot_failed));

// >>> tb/nbr_srv.sv
/* far-side load server and maintenance node.
   assumes messages are sent from the bench just after a rising edge */
`timescale 1ns/1ps
module nbr_srv (
    // clock and transmit side
    input  wire        clock,
    input  wire        tx_valid,
    input  wire [7:0]  tx_code,
    input  wire [7:0]  tx_load_num,
    output reg         tx_ready,
    // decoded messages
    output reg         rx_msg_valid,
    output reg  [2:0]  rx_proto,
    output reg  [7:0]  rx_code,
    output reg  [7:0]  rx_load_num,
    output reg  [15:0] rx_receipt,
    // image bytes
    output reg  [7:0]  rx_data,
    output reg         rx_data_valid,
    input  wire        rx_data_ready
);
    reg [7:0] byte_q[$];
    reg [7:0] ln;
    reg [7:0] b;
    initial {rx_msg_valid, rx_proto, rx_code, rx_load_num, rx_receipt, rx_data, rx_data_valid} = 0;
    // framer stalls at random
    always @(posedge clock) tx_ready <= ($urandom % 3) != 0;
    task send_msg(input [2:0] p, input [7:0] c, input [7:0] n, input [15:0] r);
        rx_proto <= p;
        rx_code <= c;
        rx_load_num <= n;
        rx_receipt <= r;
        rx_msg_valid <= 1'b1;
        @(posedge clock);
        rx_msg_valid <= 1'b0;
        rx_code <= ~c;
        @(posedge clock);
    endtask
    // each request for load number 0 or 1 gets four new random bytes, then a memory load (0) or transfer (1)
    initial forever begin
        @(posedge clock);
        if (tx_valid && tx_ready && tx_code == 8'h0A && tx_load_num < 8'h02) begin
            ln = tx_load_num;
            repeat (4) begin
                b = $urandom;
                rx_data <= b;
                rx_data_valid <= 1'b1;
                @(posedge clock);
                while (!rx_data_ready) @(posedge clock);
                byte_q.push_back(b);
            end
            rx_data_valid <= 1'b0;
            rx_data <= ~b;
            send_msg(3'h1, (ln == 8'h00) ? 8'h02 : 8'h00, ln, 16'h0000);
        end
    end
endmodule // nbr_srv

// >>> tb/nbr_requester_tb.sv
/* self-checking bench for nbr_requester with the server model on the far side.
   assumes a 4-cycle sub-tick so that 4 s is 8192 cycles */
`timescale 1ns/1ps
`include "nbr_regs.vh"
module nbr_requester_tb;
    localparam [47:0] SRV = 48'h02A0B0C0D0E1;
    localparam [7:0]  NMD = {`NBR_IMG_NAMED, `NBR_FILE_MAX_V4};
    reg clock = 0, rst = 1, boot_start = 0, operator_halt = 0, fatal_error = 0, rx_to_us = 1;
    reg diag_image_flag = 0, solicit_file_flag = 0, mem_ready = 0;
    reg [5:0] file_spec_len = 6'h00;
    reg [15:0] rc;
    reg [87:0] e, w;
    reg [87:0] exp_q[$];
    integer err_count = 0, samples_checked = 0, cyc = 0, n;
    wire rx_msg_valid, rx_data_valid, rx_data_ready, mem_valid, tx_valid, tx_ready;
    wire booting, boot_done, boot_failed;
    wire [2:0] rx_proto;
    wire [1:0] tx_image_sel;
    wire [5:0] tx_swid_len;
    wire [7:0] rx_code, rx_load_num, rx_data, mem_data, tx_code, tx_load_num;
    wire [15:0] rx_receipt, tx_receipt;
    wire [47:0] tx_dst;
    nbr_requester #(.SUBTICK_CYCLES(4)) u_dut (.clock(clock), .rst(rst),
        .boot_start(boot_start), .operator_halt(operator_halt), .fatal_error(fatal_error),
        .diag_image_flag(diag_image_flag), .solicit_file_flag(solicit_file_flag),
        .file_spec_len(file_spec_len), .rx_msg_valid(rx_msg_valid), .rx_to_us(rx_to_us),
        .rx_proto(rx_proto), .rx_ieee(1'b1), .rx_code(rx_code), .rx_src(SRV),
        .rx_load_num(rx_load_num), .rx_receipt(rx_receipt), .rx_good(1'b1), .rx_data(rx_data),
        .rx_data_valid(rx_data_valid), .rx_data_ready(rx_data_ready), .mem_data(mem_data),
        .mem_valid(mem_valid), .mem_ready(mem_ready), .tx_valid(tx_valid), .tx_code(tx_code),
        .tx_proto(), .tx_ieee(), .tx_dst(tx_dst), .tx_load_num(tx_load_num),
        .tx_receipt(tx_receipt), .tx_nopad(), .tx_swid_len(tx_swid_len),
        .tx_image_sel(tx_image_sel), .tx_ready(tx_ready), .booting(booting),
        .boot_done(boot_done), .boot_failed(boot_failed));
    nbr_srv u_srv (.clock(clock), .tx_valid(tx_valid), .tx_code(tx_code),
        .tx_load_num(tx_load_num), .tx_ready(tx_ready), .rx_msg_valid(rx_msg_valid),
        .rx_proto(rx_proto), .rx_code(rx_code), .rx_load_num(rx_load_num),
        .rx_receipt(rx_receipt), .rx_data(rx_data), .rx_data_valid(rx_data_valid),
        .rx_data_ready(rx_data_ready));
    always #10 clock = ~clock;
    always @(posedge clock) mem_ready <= $urandom % 2;
    function [87:0] mk(input [7:0] c, input [47:0] d, input [7:0] l, input [15:0] r,
        input [7:0] s);
        mk = {c, d, l, r, s};
    endfunction
    // fields compared per code
    function [87:0] msk(input [7:0] c);
        msk = {56'hFFFFFFFFFFFFFF, (c == 8'h0A) ? 8'hFF : 8'h00,
            (c == 8'h07 || c == 8'h0B) ? 16'hFFFF : 16'h0000, (c == 8'h08) ? 8'hFF : 8'h00};
    endfunction
    task check(input [87:0] seen, input [87:0] want);
        samples_checked = samples_checked + 1;
        if (seen !== want) begin
            err_count = err_count + 1;
            $display("wrong value at %0t: saw %h want %h", $time, seen, want);
        end
    endtask
    task end_sim;
        $display("mismatches %0d, comparisons %0d", err_count, samples_checked);
        if (err_count == 0 && samples_checked > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask
    task start(input s, input d);
        solicit_file_flag <= s;
        diag_image_flag <= d;
        boot_start <= 1'b1;
        @(posedge clock);
        boot_start <= 1'b0;
        wait (exp_q.size() == 0);
        @(posedge clock);
    endtask
    // scoreboard: an unexpected frame compares against its own inverse
    always @(posedge clock) begin
        cyc = cyc + 1;
        if (cyc == 20000) begin
            err_count = err_count + 1;
            end_sim;
        end
        if (tx_valid && tx_ready) begin
            e = mk(tx_code, tx_dst, tx_load_num, tx_receipt, {tx_image_sel, tx_swid_len});
            w = exp_q.size() ? exp_q.pop_front() : ~e;
            check(e & msk(w[87:80]), w & msk(w[87:80]));
        end
        if (mem_valid && mem_ready) check({80'h0, mem_data}, {80'h0, u_srv.byte_q.pop_front()});
    end
    initial begin
        void'($urandom(32'h95B0));
        repeat (6) @(posedge clock);
        rst <= 1'b0;
        @(posedge clock);
        rc = $urandom;
        file_spec_len <= 6'h2D;
        exp_q.push_back(mk(8'h08, `NBR_MCAST_DUMPLOAD, 8'h00, 16'h0, NMD));
        start(1'b1, 1'b1);
        exp_q.push_back(mk(8'h07, SRV, 8'h00, rc, 8'h00));
        exp_q.push_back(mk(8'h0B, SRV, 8'h00, ~rc, 8'h00));
        exp_q.push_back(mk(8'h08, `NBR_MCAST_DUMPLOAD, 8'h00, 16'h0, NMD));
        u_srv.send_msg(3'h2, 8'h05, 8'h00, rc);
        wait (exp_q.size() == 2);
        u_srv.send_msg(3'h2, 8'h09, 8'h00, ~rc);
        rx_to_us <= 1'b0;
        u_srv.send_msg(3'h2, 8'h05, 8'h00, rc);
        rx_to_us <= 1'b1;
        u_srv.send_msg(3'h5, 8'h05, 8'h00, rc);
        wait (exp_q.size() == 0);
        exp_q.push_back(mk(8'h08, SRV, 8'h00, 16'h0, NMD));
        for (n = 0; n < 3; n = n + 1) exp_q.push_back(mk(8'h0A, SRV, n[7:0], 16'h0, 8'h00));
        u_srv.send_msg(3'h1, 8'h03, 8'h00, 16'h0000);
        wait (boot_done && exp_q.size() == 0);
        check(88'(u_srv.byte_q.size() == 0), 88'h1);
        exp_q.push_back(mk(8'h08, `NBR_MCAST_DUMPLOAD, 8'h00, 16'h0, {`NBR_IMG_DIAG, 6'h00}));
        start(1'b0, 1'b1);
        operator_halt <= 1'b1;
        @(posedge clock);
        operator_halt <= 1'b0;
        repeat (2) @(posedge clock);
        check(88'(booting), 88'h0);
        exp_q.push_back(mk(8'h08, `NBR_MCAST_DUMPLOAD, 8'h00, 16'h0, 8'h00));
        start(1'b0, 1'b0);
        fatal_error <= 1'b1;
        @(posedge clock);
        fatal_error <= 1'b0;
        repeat (2) @(posedge clock);
        check(88'({booting, boot_failed}), 88'h1);
        u_srv.send_msg(3'h2, 8'h05, 8'h00, rc);
        repeat (8) @(posedge clock);
        end_sim;
    end
endmodule // nbr_requester_tb
